// *** rtl/amd_decoder.sv ***
// Address decoder end: mode capture, wraparound, region decode, I/O split.
// How it works
// - Capture mode from pins after reset release.
// - Pin a held low for normal mode.
// - Pin a held high with pin b low for self-programming.
// - Mode pins stay fixed during operation.
// - Data ignores address bits 31 to 26.
// - PC upper six bits stay zero.
// - Fetch address wraps modulo 64 MB.
// - Operand address overflow is truncated.
// - Sign-extend bit 25 for physical data.
// - Peripheral region decoded, fetches refused.
// - Low ROM writes go external.
// - ROM size by variant, rest prohibited.
// - RAM size by variant, rest prohibited.
// - External area 0100000H to 0FFFFFFH.
// - Word peripheral access: two halves, low first.
// - Byte register halfword read: upper undefined.
// - Byte register halfword write keeps low byte.
// - Software avoids undefined peripheral addresses.
// - Normal mode starts fetching at reset entry.
`timescale 1ns/1ps
module amd_decoder
#(
	parameter bit BIG_VARIANT = 1'b1
)
(
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic CE_IN,
	input wire logic MODE_SELECT_PIN_A_IN,
	input wire logic MODE_SELECT_PIN_B_IN,
	amd_if.dec BUS,
	output amd_pkg::amd_mode_t MODE_OUT,
	output logic MODE_VALID_OUT,
	output logic [25:0] PHYS_ADDR_OUT,
	output logic [31:0] SIGNEXT_ADDR_OUT,
	output logic MEM_STB_OUT,
	output logic MEM_WE_OUT,
	output amd_pkg::amd_region_t MEM_REGION_OUT,
	output logic [15:0] MEM_WDATA_OUT,
	input wire logic [15:0] MEM_RDATA_IN
);
	import amd_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_ONE, ST_LOW, ST_HIGH} amd_st_t;

	amd_st_t st_r;
	amd_st_t st_nxt;
	logic [25:0] phys;
	logic [25:0] rom_end;
	logic [25:0] ram_end;
	logic in_rom_area;
	logic in_rom;
	logic in_ram_area;
	logic in_ram;
	logic in_peri;
	logic in_ext;
	logic is_write;
	logic bad;
	logic split;
	amd_region_t region;
	logic [15:0] lo_hold_r;
	logic [15:0] rd_fix;
	logic [15:0] wr_fix;
	logic take;
	logic err_held;

	// Only the low 26 bits reach the map, so data images alias.
	assign phys = BUS.addr[25:0];
	assign rom_end = BIG_VARIANT ? AMD_ROM_END_BIG : AMD_ROM_END_SMALL;
	assign ram_end = BIG_VARIANT ? AMD_RAM_END_BIG : AMD_RAM_END_SMALL;
	assign is_write = (BUS.acc == AMD_ACC_WRITE);

	// Region compares on the physical address.
	assign in_rom_area = (phys <= AMD_ROM_AREA_END);
	assign in_rom = (phys <= rom_end);
	assign in_ext = (phys >= AMD_EXT_BASE) && (phys <= AMD_EXT_END);
	assign in_ram_area = (phys >= AMD_RAM_AREA_BASE) && (phys < AMD_PERI_BASE);
	assign in_ram = (phys >= AMD_RAM_BASE) && (phys <= ram_end);
	assign in_peri = (phys >= AMD_PERI_BASE);

	// Writes to the ROM area bypass the ROM, so they are never prohibited.
	always_comb
	begin
		region = AMD_REG_ERR;
		if (in_rom_area && is_write)
			region = AMD_REG_EXT;
		else if (in_rom_area && in_rom)
			region = AMD_REG_ROM;
		else if (in_ext)
			region = AMD_REG_EXT;
		else if (in_ram_area && in_ram)
			region = AMD_REG_RAM;
		else if (in_peri && BUS.acc != AMD_ACC_FETCH)
			region = AMD_REG_PERI;
	end

	assign bad = (region == AMD_REG_ERR);
	assign split = (region == AMD_REG_PERI) && (BUS.size == AMD_SZ_WORD);
	// A request is taken only when idle and the mode is known.
	assign take = (st_r == ST_IDLE) && BUS.req && MODE_VALID_OUT;
	// The error answer follows the region stored when the request was taken.
	assign err_held = (MEM_REGION_OUT == AMD_REG_ERR);

	// Byte-wide register: upper read byte undefined, here forced to zero.
	assign rd_fix = BUS.peri_byte ? {8'h00, MEM_RDATA_IN[7:0]} :
		MEM_RDATA_IN;
	assign wr_fix = BUS.peri_byte ? {8'h00, BUS.wdata[7:0]} :
		BUS.wdata[15:0];

	// Sequencer: word peripheral access takes two halfword beats.
	// A single beat answers one cycle after its strobe, because the memory
	// data only settles once the address register holds the new address.
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE:
				if (take)
					st_nxt = split ? ST_LOW : ST_ONE;
			ST_ONE:
				st_nxt = ST_IDLE;
			ST_LOW:
				st_nxt = ST_HIGH;
			ST_HIGH:
				st_nxt = ST_IDLE;
		endcase
	end

	// Mode is latched one cycle after release, never from reset itself.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			MODE_OUT <= AMD_MODE_NORMAL;
			MODE_VALID_OUT <= 1'b0;
		end
		else if (CE_IN && !MODE_VALID_OUT)
		begin
			MODE_VALID_OUT <= 1'b1;
			if (!MODE_SELECT_PIN_A_IN)
				MODE_OUT <= AMD_MODE_NORMAL;
			else if (!MODE_SELECT_PIN_B_IN)
				MODE_OUT <= AMD_MODE_FLASH;
			else
				MODE_OUT <= AMD_MODE_BAD;
		end
	end

	// Bus answer and memory strobe; address, region and write data registered at take.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			st_r <= ST_IDLE;
			lo_hold_r <= 16'h0000;
			BUS.ack <= 1'b0;
			BUS.err <= 1'b0;
			BUS.region <= AMD_REG_ERR;
			BUS.rdata <= 32'h00000000;
			PHYS_ADDR_OUT <= 26'h0000000;
			SIGNEXT_ADDR_OUT <= 32'h00000000;
			MEM_STB_OUT <= 1'b0;
			MEM_WE_OUT <= 1'b0;
			MEM_REGION_OUT <= AMD_REG_ERR;
			MEM_WDATA_OUT <= 16'h0000;
		end
		else if (CE_IN)
		begin
			st_r <= st_nxt;
			BUS.ack <= 1'b0;
			BUS.err <= 1'b0;
			MEM_STB_OUT <= 1'b0;
			if (take)
			begin
				BUS.region <= region;
				PHYS_ADDR_OUT <= {phys[25:2], split ? 2'h0 : phys[1:0]};
				SIGNEXT_ADDR_OUT <= {{6{phys[25]}}, phys};
				MEM_REGION_OUT <= region;
				MEM_WE_OUT <= is_write;
				MEM_WDATA_OUT <= wr_fix;
				MEM_STB_OUT <= !bad;
			end
			else if (st_r == ST_ONE)
			begin
				// Memory data of the single beat stands now, not at take.
				BUS.ack <= 1'b1;
				BUS.err <= err_held;
				BUS.rdata <= {16'h0000, rd_fix};
			end
			else if (st_r == ST_LOW)
			begin
				// Low half is read back now; the high beat is launched.
				lo_hold_r <= rd_fix;
				PHYS_ADDR_OUT <= {PHYS_ADDR_OUT[25:2], 2'h2};
				MEM_WDATA_OUT <= BUS.wdata[31:16];
				MEM_STB_OUT <= 1'b1;
			end
			else if (st_r == ST_HIGH)
			begin
				// High half joins the held low half in one answer.
				BUS.ack <= 1'b1;
				BUS.rdata <= {rd_fix, lo_hold_r};
			end
		end
	end

endmodule

// *** pkg/amd_pkg.sv ***
// Package with address map constants and types for the address decoder.
package amd_pkg;

	// Operating modes chosen from the mode-select pins at reset.
	typedef enum logic [1:0] {
		AMD_MODE_NORMAL,
		AMD_MODE_FLASH,
		AMD_MODE_BAD
	} amd_mode_t;

	// Regions that a physical address can fall in.
	typedef enum logic [2:0] {
		AMD_REG_ROM,
		AMD_REG_RAM,
		AMD_REG_PERI,
		AMD_REG_EXT,
		AMD_REG_ERR
	} amd_region_t;

	// Access kinds issued by the core side.
	typedef enum logic [1:0] {
		AMD_ACC_FETCH,
		AMD_ACC_READ,
		AMD_ACC_WRITE
	} amd_acc_t;

	// Transfer sizes of a data access.
	typedef enum logic [1:0] {
		AMD_SZ_BYTE,
		AMD_SZ_HALF,
		AMD_SZ_WORD
	} amd_size_t;

	localparam int AMD_AW = 32;
	localparam int AMD_PW = 26;
	localparam int AMD_DW = 32;
	localparam logic [25:0] AMD_ROM_BASE = 26'h0000000;
	localparam logic [25:0] AMD_ROM_AREA_END = 26'h00FFFFF;
	localparam logic [25:0] AMD_ROM_END_BIG = 26'h003FFFF;
	localparam logic [25:0] AMD_ROM_END_SMALL = 26'h001FFFF;
	localparam logic [25:0] AMD_EXT_BASE = 26'h0100000;
	localparam logic [25:0] AMD_EXT_END = 26'h0FFFFFF;
	localparam logic [25:0] AMD_RAM_AREA_BASE = 26'h3FF0000;
	localparam logic [25:0] AMD_RAM_BASE = 26'h3FFB000;
	localparam logic [25:0] AMD_RAM_END_BIG = 26'h3FFEFFF;
	localparam logic [25:0] AMD_RAM_END_SMALL = 26'h3FFC7FF;
	localparam logic [25:0] AMD_PERI_BASE = 26'h3FFF000;
	localparam logic [25:0] AMD_PERI_END = 26'h3FFFFFF;
	localparam logic [31:0] AMD_RESET_ENTRY = 32'h00000000;
	localparam logic [31:0] AMD_FETCH_STEP = 32'h00000004;

endpackage

// *** pkg/amd_if.sv ***
// Interface joining the core end and the address decoder end.
`timescale 1ns/1ps
interface amd_if;
	import amd_pkg::*;

	logic req;
	amd_pkg::amd_acc_t acc;
	amd_pkg::amd_size_t size;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic peri_byte;
	logic ack;
	logic err;
	amd_pkg::amd_region_t region;
	logic [31:0] rdata;

	// Core end issues requests.
	modport core
	(
		output req,
		output acc,
		output size,
		output addr,
		output wdata,
		output peri_byte,
		input ack,
		input err,
		input region,
		input rdata
	);

	// Decoder end answers them.
	modport dec
	(
		input req,
		input acc,
		input size,
		input addr,
		input wdata,
		input peri_byte,
		output ack,
		output err,
		output region,
		output rdata
	);
endinterface

// *** rtl/amd_core.sv ***
// Core end: program counter with wraparound and operand address generator.
`timescale 1ns/1ps
module amd_core
(
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic CE_IN,
	input wire logic MODE_VALID_IN,
	input wire logic BRANCH_IN,
	input wire logic [31:0] BRANCH_DISP_IN,
	input wire logic DATA_REQ_IN,
	input wire logic DATA_WRITE_IN,
	input wire amd_pkg::amd_size_t DATA_SIZE_IN,
	input wire logic DATA_PERI_BYTE_IN,
	input wire logic [31:0] DATA_BASE_IN,
	input wire logic [31:0] DATA_DISP_IN,
	input wire logic [31:0] DATA_WDATA_IN,
	amd_if.core BUS,
	output logic [31:0] PC_OUT,
	output logic DONE_OUT,
	output logic ERR_OUT,
	output logic [31:0] RDATA_OUT
);
	import amd_pkg::*;

	logic busy_r;
	logic [31:0] pc_nxt;
	logic [31:0] daddr;
	logic start;

	// Carry out of bit 25 is dropped; upper six bits stay zero.
	assign pc_nxt = {6'h00, 26'(PC_OUT[25:0] + (BRANCH_IN ?
		BRANCH_DISP_IN[25:0] : AMD_FETCH_STEP[25:0]))};
	// A 32-bit sum keeps no carry, so the data space wraps.
	assign daddr = 32'(DATA_BASE_IN + DATA_DISP_IN);
	assign start = MODE_VALID_IN && !busy_r;

	// One request outstanding; data has priority over the next fetch.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			busy_r <= 1'b0;
			PC_OUT <= AMD_RESET_ENTRY;
			DONE_OUT <= 1'b0;
			ERR_OUT <= 1'b0;
			RDATA_OUT <= 32'h00000000;
			BUS.req <= 1'b0;
			BUS.acc <= AMD_ACC_FETCH;
			BUS.size <= AMD_SZ_WORD;
			BUS.addr <= 32'h00000000;
			BUS.wdata <= 32'h00000000;
			BUS.peri_byte <= 1'b0;
		end
		else if (CE_IN)
		begin
			DONE_OUT <= 1'b0;
			BUS.req <= 1'b0;
			if (start)
			begin
				busy_r <= 1'b1;
				BUS.req <= 1'b1;
				if (DATA_REQ_IN)
				begin
					BUS.acc <= DATA_WRITE_IN ? AMD_ACC_WRITE : AMD_ACC_READ;
					BUS.size <= DATA_SIZE_IN;
					BUS.addr <= daddr;
					BUS.wdata <= DATA_WDATA_IN;
					BUS.peri_byte <= DATA_PERI_BYTE_IN;
				end
				else
				begin
					BUS.acc <= AMD_ACC_FETCH;
					BUS.size <= AMD_SZ_WORD;
					BUS.addr <= PC_OUT;
					BUS.peri_byte <= 1'b0;
				end
			end
			else if (busy_r && BUS.ack)
			begin
				busy_r <= 1'b0;
				DONE_OUT <= 1'b1;
				ERR_OUT <= BUS.err;
				RDATA_OUT <= BUS.rdata;
				if (BUS.acc == AMD_ACC_FETCH)
					PC_OUT <= pc_nxt;
			end
		end
	end

endmodule

// *** tb/amd_asserts.sv ***
// Checker of the decoder answers seen on the core-decoder link.
`timescale 1ns/1ps
module amd_asserts
(
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic req,
	input wire amd_pkg::amd_acc_t acc,
	input wire amd_pkg::amd_size_t size,
	input wire logic [31:0] addr,
	input wire logic ack,
	input wire logic err,
	input wire amd_pkg::amd_region_t region
);
	import amd_pkg::*;
	// The bench builds the large variant, so its limits apply here.
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	// Decode sees only the low 26 bits, whatever the top bits hold.
	wire [25:0] pa = addr[25:0];
	wire rd = req && acc != AMD_ACC_WRITE;
	wire split = req && pa >= AMD_PERI_BASE && acc != AMD_ACC_FETCH
		&& size == AMD_SZ_WORD;
	wire bad = pa > AMD_EXT_END && pa < AMD_RAM_BASE
		|| acc != AMD_ACC_WRITE && pa > AMD_ROM_END_BIG
		&& pa <= AMD_ROM_AREA_END;
	property p_pc;
		req && acc == AMD_ACC_FETCH |-> addr[31:26] == 6'h00;
	endproperty
	a_pc: assert property (p_pc) else $error("pc top set");
	property p_beat;
		req && !split |=> !ack ##1 ack ##1 !ack;
	endproperty
	a_beat: assert property (p_beat) else $error("no answer");
	property p_split;
		split |=> !ack [*2] ##1 ack && region == AMD_REG_PERI;
	endproperty
	a_split: assert property (p_split) else $error("split");
	property p_fpi;
		req && acc == AMD_ACC_FETCH && pa >= AMD_PERI_BASE
			|-> ##2 ack && err;
	endproperty
	a_fpi: assert property (p_fpi) else $error("io fetch");
	property p_rom;
		rd && pa <= AMD_ROM_END_BIG |=> region == AMD_REG_ROM
			##1 ack && !err;
	endproperty
	a_rom: assert property (p_rom) else $error("rom");
	property p_ram;
		req && pa >= AMD_RAM_BASE && pa <= AMD_RAM_END_BIG
			|=> region == AMD_REG_RAM ##1 ack && !err;
	endproperty
	a_ram: assert property (p_ram) else $error("ram");
	property p_ext;
		req && pa >= AMD_EXT_BASE && pa <= AMD_EXT_END
			|=> region == AMD_REG_EXT ##1 ack && !err;
	endproperty
	a_ext: assert property (p_ext) else $error("ext");
	property p_bad;
		req && bad |-> ##2 ack && err;
	endproperty
	a_bad: assert property (p_bad) else $error("no error");
endmodule

// *** tb/tb.sv ***
// Bench joining the core end to the decoder end.
`timescale 1ns/1ps
module tb;
	import amd_pkg::*;
	typedef struct {logic w; logic [31:0] b; amd_region_t r;} amd_row_t;
	// Plain decodes: write, base (offset 10H added), region expected.
	amd_row_t rows[11] = '{'{1'b0, 32'h000000F0, AMD_REG_ROM},
		'{1'b1, 32'h000000F0, AMD_REG_EXT}, '{1'b0, 32'h0003FFF0, AMD_REG_ERR},
		'{1'b0, 32'h0003FFEE, AMD_REG_ROM}, '{1'b0, 32'h03FFAFF0, AMD_REG_RAM},
		'{1'b1, 32'h03FFEFEE, AMD_REG_RAM}, '{1'b1, 32'h03FFAFEE, AMD_REG_ERR},
		'{1'b0, 32'h000FFFF0, AMD_REG_EXT}, '{1'b1, 32'h00FFFFEE, AMD_REG_EXT},
		'{1'b0, 32'hFFFFEFF0, AMD_REG_PERI}, '{1'b0, 32'hFFFFFFF8, AMD_REG_ROM}};
	amd_mode_t md[4] = '{AMD_MODE_NORMAL, AMD_MODE_NORMAL, AMD_MODE_FLASH,
		AMD_MODE_BAD};
	logic clk = 1'b0, rst_b = 1'b0, pa = 1'b0, pb = 1'b0, br = 1'b0;
	logic rq = 1'b0, wr = 1'b0, by = 1'b0, mv, stb, we, done, cerr, ge;
	amd_size_t sz = AMD_SZ_HALF;
	amd_mode_t mode;
	amd_region_t gr, gm, mr;
	logic [31:0] bd = 32'h00000000, db = 32'h00000000, wd = 32'h00000000;
	logic [31:0] sx, pc, crd, gx;
	logic [25:0] phys;
	logic [15:0] mwd, mrd;
	logic [41:0] wq[$];
	int n_mismatch = 0, cmp_count = 0;
	// Clock, and a memory that answers at once with an address pattern.
	always #5 clk = ~clk;
	assign mrd = phys[15:0] ^ 16'h5A5A;
	// Write beats are logged so that splits and discards can be seen.
	always @(posedge clk)
		if (stb && we)
			wq.push_back({phys, mwd});
	amd_if link();
	amd_decoder u_amd_decoder (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1),
		.MODE_SELECT_PIN_A_IN(pa), .MODE_SELECT_PIN_B_IN(pb), .BUS(link),
		.MODE_OUT(mode), .MODE_VALID_OUT(mv), .PHYS_ADDR_OUT(phys),
		.SIGNEXT_ADDR_OUT(sx), .MEM_STB_OUT(stb), .MEM_WE_OUT(we),
		.MEM_REGION_OUT(mr), .MEM_WDATA_OUT(mwd), .MEM_RDATA_IN(mrd));
	amd_core u_amd_core (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1),
		.MODE_VALID_IN(mv), .BRANCH_IN(br), .BRANCH_DISP_IN(bd),
		.DATA_REQ_IN(rq), .DATA_WRITE_IN(wr), .DATA_SIZE_IN(sz),
		.DATA_PERI_BYTE_IN(by), .DATA_BASE_IN(db), .DATA_DISP_IN(32'h00000010),
		.DATA_WDATA_IN(wd), .BUS(link), .PC_OUT(pc), .DONE_OUT(done),
		.ERR_OUT(cerr), .RDATA_OUT(crd));
	amd_asserts u_amd_asserts (.CLK_IN(clk), .RST_B_IN(rst_b), .req(link.req),
		.acc(link.acc), .size(link.size), .addr(link.addr), .ack(link.ack),
		.err(link.err), .region(link.region));
	task chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// Mode pins are set under reset and left alone until the next one.
	task rst(input logic a, input logic b);
		rst_b <= 1'b0;
		pa <= a;
		pb <= b;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 20 && mv !== 1'b1; i++)
			@(posedge clk);
	endtask
	// One data access; the request is dropped once it shows on the link.
	task op(input logic w, input amd_size_t s, input logic y,
		input logic [31:0] b, input logic [31:0] d);
		rq <= 1'b1;
		wr <= w;
		sz <= s;
		by <= y;
		db <= b;
		wd <= d;
		wq.delete();
		@(posedge clk);
		for (int i = 0; i < 50 && !(link.req && link.acc != AMD_ACC_FETCH); i++)
			@(posedge clk);
		rq <= 1'b0;
		for (int i = 0; i < 9 && link.ack !== 1'b1; i++)
			@(posedge clk);
		ge = link.err;
		gr = link.region;
		gm = mr;
		gx = sx;
		for (int i = 0; i < 9 && done !== 1'b1; i++)
			@(posedge clk);
		chk(done === 1'b1 && cerr === ge, "completion");
	endtask
	task complete_run;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// The run takes a few hundred cycles; this cuts a hang short.
	initial
	begin
		#100000;
		n_mismatch++;
		complete_run;
	end
	// Modes, plain decodes, then splits, byte registers and wraparound.
	initial
	begin
		logic [31:0] t;
		for (int k = 0; k < 4; k++)
		begin
			rst(k[1], k[0]);
			chk(mv === 1'b1 && mode === md[k], "mode");
		end
		rst(1'b0, 1'b0);
		for (int i = 0; i < 9 && link.req !== 1'b1; i++)
			@(posedge clk);
		chk(link.addr === AMD_RESET_ENTRY, "entry");
		foreach (rows[k])
		begin
			t = rows[k].b + 32'h00000010;
			op(rows[k].w, AMD_SZ_HALF, 1'b0, rows[k].b, 32'h1234ABCD);
			chk(gr === rows[k].r, "region");
			chk(gm === rows[k].r, "mem region");
			chk(wq.size() == int'(rows[k].w && !ge), "beats");
			chk(ge === 1'b1 || gx === {{6{t[25]}}, t[25:0]}, "sx");
		end
		op(1'b0, AMD_SZ_WORD, 1'b0, 32'h03FFF002, 32'h00000000);
		chk(crd === 32'hAA48AA4A, "split read");
		op(1'b1, AMD_SZ_WORD, 1'b0, 32'h03FFF000, 32'hCAFE1234);
		chk(wq[0] === {26'h3FFF010, 16'h1234}, "low beat");
		chk(wq[1] === {26'h3FFF012, 16'hCAFE}, "high beat");
		op(1'b0, AMD_SZ_HALF, 1'b1, 32'h03FFEFF4, 32'h00000000);
		chk(crd[15:0] === 16'h005E, "byte read");
		op(1'b1, AMD_SZ_HALF, 1'b1, 32'h03FFEFF6, 32'h0000BEEF);
		chk(wq[0] === {26'h3FFF006, 16'h00EF}, "byte write");
		rst(1'b0, 1'b0);
		for (int i = 0; i < 99 && pc !== 32'h00000010; i++)
			@(posedge clk);
		br <= 1'b1;
		bd <= 32'hFFFFFFE0;
		for (int i = 0; i < 60 && pc[25:8] !== 18'h3FFFF; i++)
			@(posedge clk);
		br <= 1'b0;
		chk(pc[31:8] === 24'h03FFFF, "branch");
		for (int i = 0; i < 60 && pc[25:8] !== 18'h00000; i++)
			@(posedge clk);
		chk(pc[31:8] === 24'h000000, "wrap");
		complete_run;
	end
endmodule
